//--- mcs_params.svh
// timing constants and select-field layout for the master configuration clock
`ifndef MCS_PARAMS_SVH
`define MCS_PARAMS_SVH

`define MCS_OSC_KHZ        25000
`define MCS_BOOT_KHZ       3100
`define MCS_SEL_W          4
`define MCS_SEL_COUNT      12
`define MCS_SEL_DEFAULT    4'h0
`define MCS_HALF_W         8
`define MCS_ENC_MAX_KHZ    15000
`define MCS_PLAIN_MAX_KHZ  33000
`define MCS_F0_KHZ         2500
`define MCS_F1_KHZ         4300
`define MCS_F2_KHZ         5400
`define MCS_F3_KHZ         6900
`define MCS_F4_KHZ         8100
`define MCS_F5_KHZ         9200
`define MCS_F6_KHZ         10000
`define MCS_F7_KHZ         13000
`define MCS_F8_KHZ         15000
`define MCS_F9_KHZ         20000
`define MCS_F10_KHZ        26000
`define MCS_F11_KHZ        33000

`endif

//--- mcs_pkg.sv
// types for the master configuration clock select block
package mcs_pkg;
    typedef enum logic [2:0] {
        MCS_ST_BOOT = 3'b001,
        MCS_ST_WAIT = 3'b010,
        MCS_ST_RUN  = 3'b100
    } mcs_state_t;
    typedef logic [7:0] mcs_half_t;
endpackage : mcs_pkg

//--- mcs_div_if.sv
// carrier between the select control and the clock divider
`timescale 1ns/1ps
`default_nettype none
interface mcs_div_if;
    mcs_pkg::mcs_half_t half_req;    // half-period wanted next
    mcs_pkg::mcs_half_t half_act;    // half-period in use
    logic               period_end;  // first cycle of the next period, same cycle the swapped value shows on half_act
    modport ctrl (output half_req, input half_act, input period_end);
    modport div  (input half_req, output half_act, output period_end);
endinterface : mcs_div_if
`default_nettype wire

//--- mcs_divider.sv
// glitch-free divider that produces the master configuration clock
`timescale 1ns/1ps
`default_nettype none
`include "mcs_params.svh"
module mcs_divider (
    input  wire logic clk,       // oscillator clock
    input  wire logic rst,       // async reset, high
    mcs_div_if.div    dif,       // half-period request and status
    output var  logic clk_out    // divided clock, registered
);
    mcs_pkg::mcs_half_t cnt_reg;
    mcs_pkg::mcs_half_t cnt_next;
    mcs_pkg::mcs_half_t half_reg;
    mcs_pkg::mcs_half_t half_next;
    logic               lvl_reg;
    logic               lvl_next;
    logic               end_reg;
    logic               end_next;

    // count half periods; a new divide only takes effect after a whole low phase
    always_comb begin
        cnt_next  = cnt_reg + 8'h01;
        half_next = half_reg;
        lvl_next  = lvl_reg;
        end_next  = 1'b0;
        if (cnt_reg >= half_reg - 8'h01) begin
            cnt_next = 8'h00;
            lvl_next = ~lvl_reg;
            if (!lvl_reg) begin
                half_next = dif.half_req;
                end_next  = 1'b1;
            end
        end
    end

    // register divider state
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_reg  <= 8'h00;
            half_reg <= 8'h04;
            lvl_reg  <= 1'b1;
            end_reg  <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            half_reg <= half_next;
            lvl_reg  <= lvl_next;
            end_reg  <= end_next;
        end
    end

    assign clk_out        = lvl_reg;
    assign dif.half_act   = half_reg;
    assign dif.period_end = end_reg;
endmodule : mcs_divider
`default_nettype wire

//--- mcs_top.sv
// master configuration clock select: boot default, bitstream select, user routing
`timescale 1ns/1ps
`default_nettype none
`include "mcs_params.svh"
// Behaviour
// - master clock is always derived from the free-running internal oscillator
// - after power-up the master clock runs at the 3.1 MHz hardware default
// - once select bits arrive, switch to the frequency they choose
// - twelve selectable frequencies from 2.5 to 33 MHz by encoded field; the divider tops out at 12.5 MHz, half the oscillator rate
// - oscillator and master clock keep running after configuration completes
// - oscillator may be routed into the general clock tree in user mode
module mcs_top #(
    parameter int SEL_W = `MCS_SEL_W      // width of select field
) (
    input  wire logic             REF_CLK,      // internal oscillator, 25 MHz
    input  wire logic             RST,          // power-up reset, high
    input  wire logic             SEL_VALID,    // select bits received, pulse
    input  wire logic [SEL_W-1:0] SEL_CODE,     // encoded frequency select
    input  wire logic             ENCRYPT_EN,   // bitstream is encrypted
    input  wire logic             CONFIG_DONE,  // configuration completed, level
    input  wire logic             OSC_ROUTE_EN, // route oscillator to clock tree
    output var  logic             MCLK,         // master configuration clock
    output var  logic             USER_MCLK,    // master clock offered to user logic
    output var  logic             USER_OSC,     // oscillator tap for the clock tree
    output var  logic [SEL_W-1:0] ACTIVE_SEL,   // select code now in force
    output var  logic             SEL_APPLIED,  // new select active, level
    output var  logic             SEL_REFUSED   // last select broke a limit, level
);
    localparam int OSC_KHZ = `MCS_OSC_KHZ;

    // half-period in oscillator cycles, rounded down and at least one
    // selections above half the oscillator rate all clip to one cycle
    function automatic mcs_pkg::mcs_half_t half_of(input int khz);
        int h;
        h = OSC_KHZ / (2 * khz);
        if (h < 1) begin
            h = 1;
        end
        return h[7:0];
    endfunction : half_of

    // frequency of each select code in kHz
    function automatic int khz_of(input logic [SEL_W-1:0] code);
        int f;
        f = 0;
        case (code)
            4'h0:    f = `MCS_F0_KHZ;
            4'h1:    f = `MCS_F1_KHZ;
            4'h2:    f = `MCS_F2_KHZ;
            4'h3:    f = `MCS_F3_KHZ;
            4'h4:    f = `MCS_F4_KHZ;
            4'h5:    f = `MCS_F5_KHZ;
            4'h6:    f = `MCS_F6_KHZ;
            4'h7:    f = `MCS_F7_KHZ;
            4'h8:    f = `MCS_F8_KHZ;
            4'h9:    f = `MCS_F9_KHZ;
            4'ha:    f = `MCS_F10_KHZ;
            4'hb:    f = `MCS_F11_KHZ;
            default: f = 0;
        endcase
        return f;
    endfunction : khz_of

    // boot divide, in force from reset until a select lands
    localparam mcs_pkg::mcs_half_t BOOT_HALF = half_of(`MCS_BOOT_KHZ);

    mcs_div_if            dif ();
    logic                 div_clk;
    mcs_pkg::mcs_state_t  st_reg;
    mcs_pkg::mcs_state_t  st_next;
    mcs_pkg::mcs_half_t   req_reg;
    mcs_pkg::mcs_half_t   req_next;
    logic [SEL_W-1:0]     sel_reg;
    logic [SEL_W-1:0]     sel_next;
    logic [SEL_W-1:0]     pend_reg;
    logic [SEL_W-1:0]     pend_next;
    logic                 refuse_reg;
    logic                 refuse_next;
    logic                 done_meta_reg;
    logic                 done_sync_reg;
    logic                 route_meta_reg;
    logic                 route_sync_reg;
    logic                 enc_meta_reg;
    logic                 enc_sync_reg;
    logic                 mclk_reg;
    logic                 mclk_next;
    logic                 applied_reg;
    logic                 applied_next;
    logic                 umclk_reg;
    logic                 umclk_next;
    logic                 osc_reg;
    logic                 osc_next;
    int                   sel_khz;
    logic                 sel_ok;

    // divider runs straight off the oscillator
    mcs_divider u_div (
        .clk     (REF_CLK),
        .rst     (RST),
        .dif     (dif.div),
        .clk_out (div_clk)
    );

    // request to the divider; it is only picked up at a period boundary
    assign dif.half_req = req_reg;

    // level inputs from configuration logic pass two flip-flops
    // only the second flop of each pair is read, the first may settle late
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            done_meta_reg  <= 1'b0;
            done_sync_reg  <= 1'b0;
            route_meta_reg <= 1'b0;
            route_sync_reg <= 1'b0;
            enc_meta_reg   <= 1'b0;
            enc_sync_reg   <= 1'b0;
        end else begin
            done_meta_reg  <= CONFIG_DONE;
            done_sync_reg  <= done_meta_reg;
            route_meta_reg <= OSC_ROUTE_EN;
            route_sync_reg <= route_meta_reg;
            enc_meta_reg   <= ENCRYPT_EN;
            enc_sync_reg   <= enc_meta_reg;
        end
    end

    // check the requested code against the table and the encryption limit
    // the limit uses the synchronised level, so it lags the pin by two cycles
    always_comb begin
        sel_khz = khz_of(SEL_CODE);
        sel_ok  = (sel_khz != 0) &&
                  (sel_khz <= (enc_sync_reg ? `MCS_ENC_MAX_KHZ : `MCS_PLAIN_MAX_KHZ));
    end

    // select sequencing: boot default, wait for period boundary, run
    always_comb begin
        st_next     = st_reg;
        req_next    = req_reg;
        sel_next    = sel_reg;
        pend_next   = pend_reg;
        refuse_next = refuse_reg;
        case (st_reg)
            mcs_pkg::MCS_ST_BOOT, mcs_pkg::MCS_ST_RUN: begin
                if (SEL_VALID) begin
                    if (sel_ok) begin
                        req_next    = half_of(sel_khz);
                        pend_next   = SEL_CODE;
                        refuse_next = 1'b0;
                        st_next     = mcs_pkg::MCS_ST_WAIT;
                    end else begin
                        refuse_next = 1'b1;
                    end
                end
            end
            mcs_pkg::MCS_ST_WAIT: begin
                // the divider swaps its half-period only at the end of a low
                // phase; matching the loaded value skips a period boundary
                // that came while the old request was still in place
                // strobes arriving here are dropped until the switch lands
                if (dif.period_end && dif.half_act == req_reg) begin
                    sel_next = pend_reg;
                    st_next  = mcs_pkg::MCS_ST_RUN;
                end
            end
            default: begin
                st_next = mcs_pkg::MCS_ST_BOOT;
            end
        endcase
        // applied flag is its own flop so the port comes straight from it
        applied_next = (st_next == mcs_pkg::MCS_ST_RUN);
    end

    // register select state; boot code reads as the default selection
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            st_reg     <= mcs_pkg::MCS_ST_BOOT;
            req_reg    <= BOOT_HALF;
            sel_reg    <= `MCS_SEL_DEFAULT;
            pend_reg   <= `MCS_SEL_DEFAULT;
            refuse_reg <= 1'b0;
            applied_reg <= 1'b0;
        end else begin
            st_reg     <= st_next;
            req_reg    <= req_next;
            sel_reg    <= sel_next;
            pend_reg   <= pend_next;
            refuse_reg <= refuse_next;
            applied_reg <= applied_next;
        end
    end

    // user-side clocks: master clock after config, oscillator tap on request
    // the oscillator tap toggles every cycle, half the oscillator rate
    always_comb begin
        mclk_next  = div_clk;
        umclk_next = done_sync_reg ? div_clk : 1'b0;
        osc_next   = route_sync_reg ? ~osc_reg : 1'b0;
    end

    // output flops
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            mclk_reg  <= 1'b0;
            umclk_reg <= 1'b0;
            osc_reg   <= 1'b0;
        end else begin
            mclk_reg  <= mclk_next;
            umclk_reg <= umclk_next;
            osc_reg   <= osc_next;
        end
    end

    // every port is driven straight from a flop
    assign MCLK        = mclk_reg;
    assign USER_MCLK   = umclk_reg;
    assign USER_OSC    = osc_reg;
    assign ACTIVE_SEL  = sel_reg;
    assign SEL_APPLIED = applied_reg;
    assign SEL_REFUSED = refuse_reg;
endmodule : mcs_top
`default_nettype wire

//--- mcs_monitor.sv
// port-level checks for the master configuration clock select
`timescale 1ns/1ps
`default_nettype none
module mcs_monitor #(
    parameter int SEL_W = 4                 // select width
) (
    input wire logic             REF_CLK,      // oscillator clock
    input wire logic             RST,          // reset
    input wire logic             SEL_VALID,    // select strobe
    input wire logic [SEL_W-1:0] SEL_CODE,     // select code
    input wire logic             ENCRYPT_EN,   // encrypted stream
    input wire logic             CONFIG_DONE,  // configuration done
    input wire logic             OSC_ROUTE_EN, // oscillator routing
    input wire logic             MCLK,         // master clock
    input wire logic             USER_MCLK,    // user copy
    input wire logic             USER_OSC,     // oscillator tap
    input wire logic [SEL_W-1:0] ACTIVE_SEL,   // code in force
    input wire logic             SEL_APPLIED,  // select applied
    input wire logic             SEL_REFUSED   // select refused
);
    logic boot_reg;
    logic boot_next;
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (RST);
    // boot phase lasts until the first select strobe
    always_comb boot_next = boot_reg && !SEL_VALID;
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST)
            boot_reg <= 1'b1;
        else
            boot_reg <= boot_next;
    end
    a_boot_code: assert property (boot_reg |-> ACTIVE_SEL == 4'h0 && !SEL_APPLIED)
        else $error("boot state not reported");
    a_boot_low: assert property ($fell(MCLK) && boot_reg |-> !MCLK [*4] ##1 MCLK)
        else $error("boot low phase not four cycles");
    a_default_rate: assert property ($rose(MCLK) && SEL_APPLIED && ACTIVE_SEL == 4'h0 |-> MCLK [*5] ##1 !MCLK [*5])
        else $error("default rate phases wrong");
    a_clock_runs: assert property ($rose(MCLK) |-> ##[2:10] $rose(MCLK))
        else $error("master clock stalled");
    a_apply_bound: assert property (SEL_VALID && SEL_APPLIED && SEL_CODE < 4'h9 && SEL_CODE != ACTIVE_SEL
        |-> ##[1:14] $changed(ACTIVE_SEL))
        else $error("select not applied in time");
    a_bad_code: assert property (SEL_VALID && SEL_APPLIED && SEL_CODE > 4'hb |=> SEL_REFUSED && $stable(ACTIVE_SEL))
        else $error("bad code not refused");
    a_enc_limit: assert property (ENCRYPT_EN [*4] ##0 (SEL_VALID && SEL_APPLIED && SEL_CODE inside {[4'h9:4'hb]})
        |=> SEL_REFUSED && $stable(ACTIVE_SEL))
        else $error("encrypted fast select not refused");
    a_user_gate: assert property (!CONFIG_DONE [*4] |-> !USER_MCLK)
        else $error("user clock before done");
    a_osc_route: assert property (OSC_ROUTE_EN [*5] |-> USER_OSC != $past(USER_OSC))
        else $error("oscillator tap not toggling");
endmodule : mcs_monitor
bind mcs_top mcs_monitor #(.SEL_W(SEL_W)) mcs_monitor_inst (.*);
`default_nettype wire

//--- mcs_cfg_model.sv
// configuration-side model: delivers select bits and status levels
`timescale 1ns/1ps
`default_nettype none
module mcs_cfg_model (
    input  wire logic       clk,        // oscillator clock
    output var  logic       sel_valid,  // select strobe
    output var  logic [3:0] sel_code,   // select field
    output var  logic       encrypt_en, // encrypted stream
    output var  logic       done,       // configuration done
    output var  logic       route_en    // oscillator routing
);
    // idle levels from time zero
    initial begin
        sel_valid = 1'b0;
        sel_code = 4'h0;
        encrypt_en = 1'b0;
        done = 1'b0;
        route_en = 1'b0;
    end
    // one strobe; field scrambled once released; bad lets a limit be broken
    task send(input logic [3:0] c, input bit bad);
        logic [3:0] cc;
        cc = (encrypt_en && c > 4'h8 && !bad) ? 4'h8 : c;
        @(posedge clk);
        sel_valid <= 1'b1;
        sel_code <= cc;
        @(posedge clk);
        sel_valid <= 1'b0;
        sel_code <= ~cc;
    endtask : send
    // stream without explicit choice carries the default code
    task send_default;
        send(4'h0, 1'b0);
    endtask : send_default
    // status levels change just after an edge
    task levels(input logic e, input logic d, input logic r);
        @(posedge clk);
        encrypt_en <= e;
        done <= d;
        route_en <= r;
    endtask : levels
endmodule : mcs_cfg_model
`default_nettype wire

//--- tb_top.sv
// self-checking bench for the master configuration clock select
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk, rst, sv, enc, done, route, mclk, umclk, uosc, app, refd, mclk_d;
    logic [3:0] code, act;
    int err_total = 0, num_checks = 0, cyc = 0;
    int fk[12] = '{2500, 4300, 5400, 6900, 8100, 9200, 10000, 13000, 15000, 20000, 26000, 33000};
    mcs_cfg_model mcs_cfg_model_inst (.clk(clk), .sel_valid(sv), .sel_code(code), .encrypt_en(enc),
        .done(done), .route_en(route));
    mcs_top mcs_top_inst (.REF_CLK(clk), .RST(rst), .SEL_VALID(sv), .SEL_CODE(code), .ENCRYPT_EN(enc),
        .CONFIG_DONE(done), .OSC_ROUTE_EN(route), .MCLK(mclk), .USER_MCLK(umclk), .USER_OSC(uosc),
        .ACTIVE_SEL(act), .SEL_APPLIED(app), .SEL_REFUSED(refd));
    // clock, edge history and hang guard
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(negedge clk) mclk_d <= mclk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            test_done;
        end
    end
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task rise(output int n);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (!(mclk === 1'b1 && mclk_d === 1'b0) && n < 50);
    endtask : rise
    // period of the master clock in oscillator cycles
    task per(input int e);
        int n;
        rise(n);
        rise(n);
        chk(8'(n), 8'(e));
    endtask : per
    task wait_app(input logic [3:0] c);
        int k;
        k = 0;
        while (!(app === 1'b1 && act === c) && k < 40) begin
            @(negedge clk);
            k++;
        end
        chk(8'(act), 8'(c));
        chk(8'(app), 8'h01);
    endtask : wait_app
    task t_boot;
        chk(8'(act), 8'h00);
        chk(8'(app), 8'h00);
        per(8);
        $display("test boot done");
    endtask : t_boot
    task t_default;
        mcs_cfg_model_inst.send_default;
        wait_app(4'h0);
        per(10);
        $display("test default done");
    endtask : t_default
    task t_table;
        int h;
        for (int i = 1; i < 12; i++) begin
            mcs_cfg_model_inst.send(4'(i), 1'b0);
            wait_app(4'(i));
            h = 12500 / fk[i];
            per(2 * (h < 1 ? 1 : h));
        end
        $display("test table done");
    endtask : t_table
    task t_refuse;
        mcs_cfg_model_inst.levels(1'b1, 1'b0, 1'b0);
        repeat (4) @(posedge clk);
        for (int i = 9; i < 13; i++) begin
            mcs_cfg_model_inst.send(4'(i), 1'b1);
            repeat (2) @(negedge clk);
            chk(8'(refd), 8'h01);
            chk(8'(act), 8'h0b);
        end
        mcs_cfg_model_inst.send(4'h8, 1'b0);
        wait_app(4'h8);
        chk(8'(refd), 8'h00);
        $display("test refuse done");
    endtask : t_refuse
    task t_user;
        int n, k;
        logic o;
        repeat (20) @(negedge clk);
        chk(8'(umclk), 8'h00);
        mcs_cfg_model_inst.levels(1'b0, 1'b1, 1'b1);
        repeat (5) @(negedge clk);
        n = 0;
        k = 0;
        o = uosc;
        repeat (8) begin
            @(negedge clk);
            n += int'(umclk === 1'b1);
            k += int'(uosc !== o);
            o = uosc;
        end
        chk(8'(n), 8'h04);
        chk(8'(k), 8'h08);
        mcs_cfg_model_inst.levels(1'b0, 1'b0, 1'b0);
        repeat (5) @(negedge clk);
        chk(8'(uosc), 8'h00);
        chk(8'(umclk), 8'h00);
        $display("test user done");
    endtask : t_user
    task test_done;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : test_done
    // main sequence, with a second reset in mid-run
    initial begin
        rst = 1'b1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_boot;
        t_default;
        t_table;
        t_refuse;
        t_user;
        @(posedge clk);
        rst <= 1'b1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_boot;
        test_done;
    end
endmodule : tb_top
`default_nettype wire
